//--- rtl/insn_decode_pkg.sv
// Shared constants and types for the 14-bit instruction decoder
package insn_decode_pkg;

  // ****************************************************
  // Word layout
  // ****************************************************
  localparam int INSN_W = 14;
  localparam int FILE_ADDR_W = 7;
  localparam int BIT_NUM_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int DEST_BIT_POS = 7;
  localparam int BIT_NUM_LSB = 7;
  localparam int QUARTERS_PER_CYCLE = 4;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [13:0] INSN_RESET = 14'h0000;

  // ****************************************************
  // Fixed control codes
  // ****************************************************
  localparam logic [13:0] CODE_SUB_RETURN = 14'h0008;
  localparam logic [13:0] CODE_INT_RETURN = 14'h0009;
  localparam logic [13:0] CODE_WDOG_CLEAR = 14'h0064;
  localparam logic [13:0] CODE_STANDBY = 14'h0063;
  localparam logic [13:0] NOP_MASK = 14'h3f9f;

  // ****************************************************
  // Operations
  // ****************************************************
  typedef enum logic [5:0] {
    OP_NO_OPERATION = 6'h00, OP_STORE_ACC_TO_FILE, OP_CLEAR_FILE, OP_CLEAR_ACCUMULATOR,
    OP_SUB_ACC_FROM_FILE, OP_DECREMENT_FILE, OP_OR_ACC_WITH_FILE, OP_AND_ACC_WITH_FILE,
    OP_XOR_ACC_WITH_FILE, OP_ADD_ACC_TO_FILE, OP_MOVE_FILE, OP_COMPLEMENT_FILE,
    OP_INCREMENT_FILE, OP_DECREMENT_SKIP_ZERO, OP_ROTATE_RIGHT_CARRY,
    OP_ROTATE_LEFT_CARRY, OP_SWAP_NIBBLES, OP_INCREMENT_SKIP_ZERO,
    OP_BIT_CLEAR_OP, OP_BIT_SET_OP, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET,
    OP_CALL_OP, OP_JUMP_OP, OP_LOAD_LITERAL, OP_RETURN_WITH_LITERAL,
    OP_OR_LITERAL, OP_AND_LITERAL, OP_XOR_LITERAL, OP_SUB_FROM_LITERAL, OP_ADD_LITERAL,
    OP_SUB_RETURN, OP_INTERRUPT_RETURN, OP_WATCHDOG_CLEAR_OP, OP_STANDBY
  } op_t;

  typedef enum logic [1:0] {
    FMT_BYTE = 2'h0, FMT_BIT = 2'h1, FMT_LITERAL = 2'h2, FMT_CONTROL = 2'h3
  } fmt_t;

  // Flag-effect bundle: carry, digit carry, zero, timeout/powerdown
  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
    logic timeout_powerdown;
  } flags_t;

  // Decoded instruction as presented to the datapath
  typedef struct packed {
    op_t op;
    fmt_t fmt;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic dest_file;
    logic [BIT_NUM_W-1:0] bit_num;
    logic [LIT8_W-1:0] lit8;
    logic [LIT11_W-1:0] lit11;
    flags_t flags;
    logic fixed_two_cycle;
    logic skip_capable;
    logic writes_file;
    logic writes_acc;
    logic pin_sample;
    logic push_stack;
    logic load_pc_from_latch;
    logic wdog_clear;
    logic pd_clear;
  } decoded_t;

endpackage

//--- rtl/insn_decoder.sv
// Registered decoder and instruction-cycle sequencer for the 14-bit core
`timescale 1ns/1ps

// What this block does
// - Byte ops: opcode 13:8, dest 7, file 6:0.
// - Dest zero writes accumulator, one writes file.
// - Bit ops: opcode 13:10, bit 9:7, file.
// - Literal ops: opcode 13:8, literal 7:0.
// - Call/jump: opcode 13:11, target 10:0.
// - One cycle; two if branching or skipping.
// - Instruction cycle equals four clock periods.
// - Self-modified port reads sampled pin levels.
// - Writing timer zero clears assigned prescaler.
// - Add/sub with file update C, DC, Z.
// - AND/OR/XOR with file affect zero only.
// - Complement/decrement/increment/move affect zero only.
// - Skip-on-zero counts: no flags, skip doubles cycles.
// - Rotates update carry; swap changes nothing.
// - Store, clear file, clear accumulator forms.
// - Bit clear/set/test forms, no flags.
// - Literal add/sub: accumulator, C, DC, Z.
// - Literal AND/OR/XOR: accumulator, zero only.
// - Load literal one cycle; literal return two.
// - Call and jump: two cycles, no flags.
// - Fixed return, watchdog, standby codes.
// - Don't-care bits ignored; no-operation pattern.
// - Bit clear/set touch only selected bit.
// - Call pushes next address, loads latch bits.
// - Watchdog clear resets counter, prescaler, flags.
module insn_decoder (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Instruction fetch
  input wire logic [13:0] INSN_WORD,
  // Datapath feedback
  input wire logic COND_TRUE,
  input wire logic FILE_IS_PORT,
  input wire logic FILE_IS_TIMER0,
  input wire logic PRESCALER_ON_TIMER0,
  // Decoded outputs
  output insn_decode_pkg::decoded_t DECODED,
  output logic [7:0] BIT_MASK,
  output logic INSN_LOAD,
  output logic [1:0] QUARTER,
  output logic SECOND_CYCLE,
  output logic EXEC_EN,
  output logic TIMER_PRESCALE_CLR
);
  import insn_decode_pkg::*;

  // ****************************************************
  // Decode functions
  // ****************************************************
  function automatic decoded_t decode_word(input logic [13:0] w);
    decoded_t d;
    d = '0;
    d.op = OP_NO_OPERATION;
    d.fmt = FMT_BYTE;
    d.file_addr = w[FILE_ADDR_W-1:0];
    d.dest_file = w[DEST_BIT_POS];
    d.bit_num = w[BIT_NUM_LSB +: BIT_NUM_W];
    d.lit8 = w[LIT8_W-1:0];
    d.lit11 = w[LIT11_W-1:0];
    unique case (w[13:12])
      2'h0: begin
        d.fmt = FMT_BYTE;
        unique case (w[11:8])
          4'h0: begin
            if (w[7]) begin
              d.op = OP_STORE_ACC_TO_FILE;
            end else if (w == CODE_SUB_RETURN) begin
              d.op = OP_SUB_RETURN;
              d.fixed_two_cycle = 1'b1;
              d.fmt = FMT_CONTROL;
            end else if (w == CODE_INT_RETURN) begin
              d.op = OP_INTERRUPT_RETURN;
              d.fixed_two_cycle = 1'b1;
              d.fmt = FMT_CONTROL;
            end else if (w == CODE_WDOG_CLEAR) begin
              d.op = OP_WATCHDOG_CLEAR_OP;
              d.flags.timeout_powerdown = 1'b1;
              d.wdog_clear = 1'b1;
              d.fmt = FMT_CONTROL;
            end else if (w == CODE_STANDBY) begin
              d.op = OP_STANDBY;
              d.flags.timeout_powerdown = 1'b1;
              d.wdog_clear = 1'b1;
              d.pd_clear = 1'b1;
              d.fmt = FMT_CONTROL;
            end else begin
              d.op = OP_NO_OPERATION;
              d.fmt = FMT_CONTROL;
            end
          end
          // clear file or accumulator, zero set
          4'h1: begin
            d.op = w[7] ? OP_CLEAR_FILE : OP_CLEAR_ACCUMULATOR;
            d.flags.zero = 1'b1;
          end
          4'h2: begin
            d.op = OP_SUB_ACC_FROM_FILE;
            d.flags = '{carry: 1'b1, digit_carry: 1'b1, zero: 1'b1, timeout_powerdown: 1'b0};
          end
          4'h7: begin
            d.op = OP_ADD_ACC_TO_FILE;
            d.flags = '{carry: 1'b1, digit_carry: 1'b1, zero: 1'b1, timeout_powerdown: 1'b0};
          end
          4'h4: begin
            d.op = OP_OR_ACC_WITH_FILE;
            d.flags.zero = 1'b1;
          end
          4'h5: begin
            d.op = OP_AND_ACC_WITH_FILE;
            d.flags.zero = 1'b1;
          end
          4'h6: begin
            d.op = OP_XOR_ACC_WITH_FILE;
            d.flags.zero = 1'b1;
          end
          4'h3: begin
            d.op = OP_DECREMENT_FILE;
            d.flags.zero = 1'b1;
          end
          4'h8: begin
            d.op = OP_MOVE_FILE;
            d.flags.zero = 1'b1;
          end
          4'h9: begin
            d.op = OP_COMPLEMENT_FILE;
            d.flags.zero = 1'b1;
          end
          4'ha: begin
            d.op = OP_INCREMENT_FILE;
            d.flags.zero = 1'b1;
          end
          4'hb: begin
            d.op = OP_DECREMENT_SKIP_ZERO;
            d.skip_capable = 1'b1;
          end
          4'hf: begin
            d.op = OP_INCREMENT_SKIP_ZERO;
            d.skip_capable = 1'b1;
          end
          4'hc: begin
            d.op = OP_ROTATE_RIGHT_CARRY;
            d.flags.carry = 1'b1;
          end
          4'hd: begin
            d.op = OP_ROTATE_LEFT_CARRY;
            d.flags.carry = 1'b1;
          end
          4'he: d.op = OP_SWAP_NIBBLES;
        endcase
        if (d.op inside {OP_STORE_ACC_TO_FILE, OP_CLEAR_FILE}) begin
          d.writes_file = 1'b1;
        end else if (d.op == OP_CLEAR_ACCUMULATOR) begin
          d.writes_acc = 1'b1;
        end else if (d.fmt == FMT_BYTE) begin
          d.writes_file = w[DEST_BIT_POS];
          d.writes_acc = ~w[DEST_BIT_POS];
        end
      end
      2'h1: begin
        d.fmt = FMT_BIT;
        unique case (w[11:10])
          2'h0: d.op = OP_BIT_CLEAR_OP;
          2'h1: d.op = OP_BIT_SET_OP;
          2'h2: d.op = OP_TEST_SKIP_IF_CLEAR;
          2'h3: d.op = OP_TEST_SKIP_IF_SET;
        endcase
        d.writes_file = ~w[11];
        d.skip_capable = w[11];
      end
      2'h2: begin
        d.fmt = FMT_CONTROL;
        d.op = w[11] ? OP_JUMP_OP : OP_CALL_OP;
        d.push_stack = ~w[11];
        d.load_pc_from_latch = 1'b1;
        d.fixed_two_cycle = 1'b1;
      end
      2'h3: begin
        d.fmt = FMT_LITERAL;
        d.writes_acc = 1'b1;
        // don't-care bits 9:8 on some forms
        if (w[11:10] == 2'h0) begin
          d.op = OP_LOAD_LITERAL;
        end else if (w[11:10] == 2'h1) begin
          d.op = OP_RETURN_WITH_LITERAL;
          d.fixed_two_cycle = 1'b1;
        end else if (w[11:9] == 3'h7) begin
          d.op = OP_ADD_LITERAL;
          d.flags = '{carry: 1'b1, digit_carry: 1'b1, zero: 1'b1, timeout_powerdown: 1'b0};
        end else if (w[11:9] == 3'h6) begin
          d.op = OP_SUB_FROM_LITERAL;
          d.flags = '{carry: 1'b1, digit_carry: 1'b1, zero: 1'b1, timeout_powerdown: 1'b0};
        end else begin
          d.flags.zero = (w[9:8] != 2'h3);
          d.writes_acc = (w[9:8] != 2'h3);
          unique case (w[9:8])
            2'h0: d.op = OP_OR_LITERAL;
            2'h1: d.op = OP_AND_LITERAL;
            2'h2: d.op = OP_XOR_LITERAL;
            2'h3: d.op = OP_NO_OPERATION;
          endcase
        end
      end
    endcase
    // read-modify-write of an I/O port samples pins
    d.pin_sample = d.writes_file && d.op != OP_STORE_ACC_TO_FILE && d.op != OP_CLEAR_FILE;
    return d;
  endfunction

  // one-hot mask for the selected bit
  function automatic logic [7:0] bit_mask(input logic [2:0] n);
    return 8'h01 << n;
  endfunction

  // ****************************************************
  // Quarter counter and cycle sequencer
  // ****************************************************
  typedef enum logic [1:0] {
    ST_FIRST = 2'b01,
    ST_FILL = 2'b10
  } seq_t;

  seq_t state_ff, nxt_state;
  logic [1:0] quarter_ff, nxt_quarter;
  decoded_t dec_ff, nxt_dec;
  logic [7:0] mask_ff, nxt_mask;
  logic load_ff, nxt_load;
  logic exec_ff, nxt_exec;
  logic fill_ff, nxt_fill;
  logic tclr_ff, nxt_tclr;
  logic cycle_end;
  logic two_cycle;

  assign cycle_end = (quarter_ff == QUARTER_LAST);
  // second cycle when branching or test true
  assign two_cycle = dec_ff.fixed_two_cycle || (dec_ff.skip_capable && COND_TRUE);

  always_comb begin
    nxt_quarter = quarter_ff + 2'h1;
    nxt_state = state_ff;
    nxt_dec = dec_ff;
    nxt_mask = mask_ff;
    nxt_load = 1'b0;
    nxt_exec = exec_ff;
    nxt_fill = fill_ff;
    nxt_tclr = 1'b0;
    if (cycle_end) begin
      unique case (state_ff)
        ST_FIRST: begin
          if (two_cycle) begin
            // Filler cycle: decoded word is held, execution disabled
            nxt_state = ST_FILL;
            nxt_exec = 1'b0;
            nxt_fill = 1'b1;
          end else begin
            nxt_dec = decode_word(INSN_WORD);
            nxt_mask = bit_mask(INSN_WORD[BIT_NUM_LSB +: BIT_NUM_W]);
            nxt_load = 1'b1;
            nxt_exec = 1'b1;
            nxt_fill = 1'b0;
          end
        end
        ST_FILL: begin
          nxt_state = ST_FIRST;
          nxt_dec = decode_word(INSN_WORD);
          nxt_mask = bit_mask(INSN_WORD[BIT_NUM_LSB +: BIT_NUM_W]);
          nxt_load = 1'b1;
          nxt_exec = 1'b1;
          nxt_fill = 1'b0;
        end
      endcase
    end
    // timer write clears prescaler at write quarter
    if (cycle_end && exec_ff && dec_ff.writes_file && FILE_IS_TIMER0 && PRESCALER_ON_TIMER0) begin
      nxt_tclr = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_FIRST;
      quarter_ff <= 2'h0;
      dec_ff <= '0;
      mask_ff <= 8'h01;
      load_ff <= 1'b0;
      exec_ff <= 1'b0;
      fill_ff <= 1'b0;
      tclr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      quarter_ff <= nxt_quarter;
      dec_ff <= nxt_dec;
      mask_ff <= nxt_mask;
      load_ff <= nxt_load;
      exec_ff <= nxt_exec;
      fill_ff <= nxt_fill;
      tclr_ff <= nxt_tclr;
    end
  end

  // Pin sampling only matters when the file is an I/O port
  always_comb begin
    DECODED = dec_ff;
    DECODED.pin_sample = dec_ff.pin_sample & FILE_IS_PORT;
  end
  assign BIT_MASK = mask_ff;
  assign INSN_LOAD = load_ff;
  assign QUARTER = quarter_ff;
  assign SECOND_CYCLE = fill_ff;
  assign EXEC_EN = exec_ff;
  assign TIMER_PRESCALE_CLR = tclr_ff;

  // ****************************************************
  // Checks
  // ****************************************************
  sequence load_then_three;
    INSN_LOAD ##1 !INSN_LOAD [*3];
  endsequence

  quarter_period_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    INSN_LOAD |-> ##4 (INSN_LOAD || SECOND_CYCLE))
    else $error("instruction cycle not four clocks");

  load_spacing_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    INSN_LOAD |-> load_then_three)
    else $error("load repeated within one cycle");

  branch_fill_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (INSN_LOAD && DECODED.op inside {OP_CALL_OP, OP_JUMP_OP}) |-> ##4 SECOND_CYCLE ##4 INSN_LOAD)
    else $error("branch did not take two cycles");

  fill_noexec_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    SECOND_CYCLE |-> !EXEC_EN)
    else $error("filler cycle executed");

  single_cycle_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (INSN_LOAD && DECODED.op == OP_NO_OPERATION) |-> ##4 !SECOND_CYCLE)
    else $error("no-operation took two cycles");

  dest_steer_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (DECODED.fmt == FMT_BYTE && DECODED.op == OP_MOVE_FILE)
      |-> (DECODED.writes_file == DECODED.dest_file && DECODED.writes_acc == !DECODED.dest_file))
    else $error("destination select misrouted");

  mask_match_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    INSN_LOAD |-> BIT_MASK == (8'h01 << DECODED.bit_num))
    else $error("bit mask wrong");

  logic_flags_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (DECODED.op inside {OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE, OP_XOR_ACC_WITH_FILE})
      |-> DECODED.flags == 4'b0010)
    else $error("logic op flag set wrong");

  skip_flags_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (DECODED.op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO}) |-> DECODED.flags == 4'b0)
    else $error("skip count changed flags");

  prescale_clr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    TIMER_PRESCALE_CLR |-> $past(EXEC_EN) && $past(DECODED.writes_file) && QUARTER == 2'h0)
    else $error("prescaler clear without timer write");

endmodule

//--- testbench/mcu_14bit_instruction_decode_bench.sv
// Self-checking bench for the 14-bit instruction decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fails++; $display("FAIL %s expected %h seen %h", nm, e, g); end end
module mcu_14bit_instruction_decode_bench;
  import insn_decode_pkg::*;
  localparam int NDIR = 42;
  localparam logic [13:0] dir_tab [0:NDIR-1] = '{
    14'h0000, 14'h0020, 14'h0040, 14'h0060, 14'h0001, 14'h0085, 14'h0185, 14'h0105,
    14'h017f, 14'h0205, 14'h0385, 14'h0405, 14'h0585, 14'h0605, 14'h0785, 14'h0805,
    14'h0985, 14'h0a05, 14'h0b85, 14'h0c05, 14'h0d85, 14'h0e85, 14'h0f85, 14'h1385,
    14'h1405, 14'h1a85, 14'h1f85, 14'h2123, 14'h2fff, 14'h3055, 14'h3455, 14'h3e55,
    14'h3f55, 14'h3c55, 14'h3855, 14'h3955, 14'h3a55, 14'h3b55, 14'h0008, 14'h0009,
    14'h0064, 14'h0063};
  logic sys_clk;
  logic rst_n;
  logic [13:0] insn_word;
  logic cond_true;
  logic file_is_port;
  logic file_is_timer0;
  logic presc_on_timer0;
  decoded_t decoded;
  logic [7:0] bit_mask;
  logic insn_load;
  logic [1:0] quarter;
  logic second_cycle;
  logic exec_en;
  logic presc_clr;
  int fails = 0;
  int checks = 0;
  int seed = 66;
  int cyc = 0;
  int dir_idx = 1;

  insn_decoder dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .INSN_WORD(insn_word), .COND_TRUE(cond_true),
    .FILE_IS_PORT(file_is_port), .FILE_IS_TIMER0(file_is_timer0),
    .PRESCALER_ON_TIMER0(presc_on_timer0), .DECODED(decoded), .BIT_MASK(bit_mask),
    .INSN_LOAD(insn_load), .QUARTER(quarter), .SECOND_CYCLE(second_cycle),
    .EXEC_EN(exec_en), .TIMER_PRESCALE_CLR(presc_clr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // ****************************************************
  // Reference decode
  // ****************************************************
  function automatic decoded_t ref_decode(input logic [13:0] w);
    decoded_t r;
    logic [3:0] n;
    logic dop;
    r = '0;
    n = w[11:8];
    dop = (w[13:12] == 2'h0) && (n >= 4'h2);
    r.file_addr = w[6:0];
    r.dest_file = w[7];
    r.bit_num = w[9:7];
    r.lit8 = w[7:0];
    r.lit11 = w[10:0];
    r.op = OP_NO_OPERATION;
    r.fmt = (w[13:12] == 2'h1) ? FMT_BIT : FMT_BYTE;
    case (w[13:12])
      2'h0: begin
        case (n)
          4'h0: begin
            if (w[7]) r.op = OP_STORE_ACC_TO_FILE;
            else if (w == 14'h0008) r.op = OP_SUB_RETURN;
            else if (w == 14'h0009) r.op = OP_INTERRUPT_RETURN;
            else if (w == 14'h0064) r.op = OP_WATCHDOG_CLEAR_OP;
            else if (w == 14'h0063) r.op = OP_STANDBY;
          end
          4'h1: r.op = w[7] ? OP_CLEAR_FILE : OP_CLEAR_ACCUMULATOR;
          4'h2: r.op = OP_SUB_ACC_FROM_FILE;
          4'h3: r.op = OP_DECREMENT_FILE;
          4'h4: r.op = OP_OR_ACC_WITH_FILE;
          4'h5: r.op = OP_AND_ACC_WITH_FILE;
          4'h6: r.op = OP_XOR_ACC_WITH_FILE;
          4'h7: r.op = OP_ADD_ACC_TO_FILE;
          4'h8: r.op = OP_MOVE_FILE;
          4'h9: r.op = OP_COMPLEMENT_FILE;
          4'ha: r.op = OP_INCREMENT_FILE;
          4'hb: r.op = OP_DECREMENT_SKIP_ZERO;
          4'hc: r.op = OP_ROTATE_RIGHT_CARRY;
          4'hd: r.op = OP_ROTATE_LEFT_CARRY;
          4'he: r.op = OP_SWAP_NIBBLES;
          default: r.op = OP_INCREMENT_SKIP_ZERO;
        endcase
      end
      2'h1: begin
        case (w[11:10])
          2'h0: r.op = OP_BIT_CLEAR_OP;
          2'h1: r.op = OP_BIT_SET_OP;
          2'h2: r.op = OP_TEST_SKIP_IF_CLEAR;
          default: r.op = OP_TEST_SKIP_IF_SET;
        endcase
      end
      2'h2: r.op = w[11] ? OP_JUMP_OP : OP_CALL_OP;
      default: begin
        if (w[11:10] == 2'h0) r.op = OP_LOAD_LITERAL;
        else if (w[11:10] == 2'h1) r.op = OP_RETURN_WITH_LITERAL;
        else if (w[11:9] == 3'h7) r.op = OP_ADD_LITERAL;
        else if (w[11:9] == 3'h6) r.op = OP_SUB_FROM_LITERAL;
        else if (n == 4'h8) r.op = OP_OR_LITERAL;
        else if (n == 4'h9) r.op = OP_AND_LITERAL;
        else if (n == 4'ha) r.op = OP_XOR_LITERAL;
      end
    endcase
    case (r.op)
      OP_ADD_ACC_TO_FILE, OP_SUB_ACC_FROM_FILE, OP_ADD_LITERAL, OP_SUB_FROM_LITERAL: r.flags = 4'b1110;
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: r.flags = 4'b1000;
      OP_WATCHDOG_CLEAR_OP, OP_STANDBY: r.flags = 4'b0001;
      OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE, OP_XOR_ACC_WITH_FILE, OP_COMPLEMENT_FILE,
      OP_DECREMENT_FILE, OP_INCREMENT_FILE, OP_MOVE_FILE, OP_CLEAR_FILE, OP_CLEAR_ACCUMULATOR,
      OP_AND_LITERAL, OP_OR_LITERAL, OP_XOR_LITERAL: r.flags = 4'b0010;
      default: r.flags = 4'b0000;
    endcase
    r.fixed_two_cycle = r.op inside {OP_CALL_OP, OP_JUMP_OP, OP_RETURN_WITH_LITERAL,
      OP_SUB_RETURN, OP_INTERRUPT_RETURN};
    r.skip_capable = r.op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO,
      OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET};
    r.push_stack = (r.op == OP_CALL_OP);
    // Both single-cycle control codes restart the watchdog; only standby drops power-down
    r.wdog_clear = r.op inside {OP_WATCHDOG_CLEAR_OP, OP_STANDBY};
    r.pd_clear = (r.op == OP_STANDBY);
    r.load_pc_from_latch = r.op inside {OP_CALL_OP, OP_JUMP_OP};
    r.pin_sample = (dop && w[7]) || (r.op inside {OP_BIT_CLEAR_OP, OP_BIT_SET_OP});
    r.writes_file = r.pin_sample || (r.op inside {OP_STORE_ACC_TO_FILE, OP_CLEAR_FILE});
    r.writes_acc = (dop && !w[7]) || (r.op inside {OP_CLEAR_ACCUMULATOR, OP_LOAD_LITERAL,
      OP_RETURN_WITH_LITERAL, OP_ADD_LITERAL, OP_SUB_FROM_LITERAL, OP_AND_LITERAL,
      OP_OR_LITERAL, OP_XOR_LITERAL});
    return r;
  endfunction

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset();
    decoded_t zd;
    zd = '0;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("reset decoded", zd, decoded)
    `CHK("reset bit_mask", 8'h01, bit_mask)
    `CHK("reset outputs", 5'h00, {insn_load, exec_en, second_cycle, presc_clr, quarter[0]})
    @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  task automatic check_load(input logic [13:0] w, input logic port);
    decoded_t e;
    e = ref_decode(w);
    `CHK("op", e.op, decoded.op)
    `CHK("flags", e.flags, decoded.flags)
    `CHK("fixed_two", e.fixed_two_cycle, decoded.fixed_two_cycle)
    `CHK("skip_capable", e.skip_capable, decoded.skip_capable)
    `CHK("push_stack", e.push_stack, decoded.push_stack)
    `CHK("writes_acc", e.writes_acc, decoded.writes_acc)
    `CHK("quarter", 2'h0, quarter)
    `CHK("exec_en", 1'b1, exec_en)
    `CHK("wdog_clear", e.wdog_clear, decoded.wdog_clear)
    `CHK("pd_clear", e.pd_clear, decoded.pd_clear)
    `CHK("load_pc_latch", e.load_pc_from_latch, decoded.load_pc_from_latch)
    if (!(w[13:12] == 2'h0 && w[11:8] >= 4'h2 && !w[7]))
      `CHK("pin_sample", e.pin_sample & port, decoded.pin_sample)
    if (w[13:12] == 2'h0 && w[11:8] >= 4'h1) begin
      `CHK("byte fields", {FMT_BYTE, w[7], w[6:0]}, {decoded.fmt, decoded.dest_file, decoded.file_addr})
      `CHK("writes_file", e.writes_file, decoded.writes_file)
    end
    if (w[13:12] == 2'h1) begin
      `CHK("bit fields", {FMT_BIT, w[9:7], w[6:0]}, {decoded.fmt, decoded.bit_num, decoded.file_addr})
      `CHK("bit_mask", 8'h01 << w[9:7], bit_mask)
      `CHK("writes_file", e.writes_file, decoded.writes_file)
    end
    if (w[13:12] == 2'h3) `CHK("lit8", w[7:0], decoded.lit8)
    if (w[13:12] == 2'h2) `CHK("lit11", w[10:0], decoded.lit11)
  endtask

  task automatic run_seq(input int cnt);
    decoded_t e;
    logic [13:0] cur_w;
    logic [13:0] nxt_w;
    logic [31:0] rv;
    logic c_cond;
    logic c_port;
    logic c_tmr;
    logic c_psc;
    logic two;
    logic prev_two;
    int n;
    int last;
    prev_two = 1'b0;
    last = 0;
    cur_w = insn_word;
    for (int k = 0; k < cnt; k++) begin
      n = 0;
      while (insn_load !== 1'b1 && n < 16) begin
        @(negedge sys_clk);
        n++;
      end
      if (k == 0) `CHK("first load", 5, n)
      else `CHK("load spacing", prev_two ? 8 : 4, cyc - last)
      last = cyc;
      c_cond = cond_true;
      c_port = file_is_port;
      c_tmr = file_is_timer0;
      c_psc = presc_on_timer0;
      check_load(cur_w, c_port);
      e = ref_decode(cur_w);
      two = e.fixed_two_cycle || (e.skip_capable && c_cond);
      rv = $random(seed);
      nxt_w = (dir_idx < NDIR) ? dir_tab[dir_idx] : rv[13:0];
      dir_idx++;
      @(posedge sys_clk);
      insn_word <= nxt_w;
      repeat (3) @(posedge sys_clk);
      rv = $random(seed);
      {cond_true, file_is_port, file_is_timer0, presc_on_timer0} <= rv[3:0];
      @(negedge sys_clk);
      `CHK("second_cycle", two, second_cycle)
      `CHK("exec_en filler", !two, exec_en)
      `CHK("prescale clr", e.writes_file & c_tmr & c_psc, presc_clr)
      cur_w = nxt_w;
      prev_two = two;
    end
  endtask

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    insn_word = dir_tab[0];
    cond_true = 1'b1;
    file_is_port = 1'b1;
    file_is_timer0 = 1'b1;
    presc_on_timer0 = 1'b1;
    do_reset();
    run_seq(150);
    // Reset lands in mid-instruction on purpose
    do_reset();
    run_seq(150);
    final_report();
  end

  // Whole run needs at most about 2400 clocks; ample margin
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule
